// ### rtl/sbf_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module sbf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);

  if (DEPTH < 2 || WIDTH < 1) begin : gBadSize
    $error("sbf_fifo: DEPTH must be 2 or more and WIDTH 1 or more");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_q;
  logic [PW-1:0] rdPtr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;

  assign inReady = count_q != CW'(DEPTH);
  assign outValid = count_q != '0;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[rdPtr_q];
  assign count = count_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == LAST_IDX) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == LAST_IDX) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end
endmodule // sbf_fifo
`default_nettype wire

// ### rtl/sbf_pkg.sv
package sbf_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MIN_IDLE_NS = 100000;
  localparam int MIN_IDLE_CYC = (MIN_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
  // buffers
  localparam int RX_DEPTH = 2100;
  localparam int TX_DEPTH = 2048;
  localparam int CNT_W = 12;
  localparam logic [11:0] STOP_MAX = 12'h823;
  localparam logic [11:0] STOP_MARGIN = 12'h011;
  localparam logic [11:0] STOP_RESET = 12'h7f3;
  localparam logic [11:0] ESC_COUNT = 12'h003;
  localparam logic [11:0] ADDR_BYTES = 12'h004;
  // reset values
  localparam logic [15:0] GUARD_RESET = 16'h03e8;
  localparam logic [7:0] ESC_RESET = 8'h2b;
  localparam logic [7:0] IDLE_RESET = 8'h03;
  localparam logic [19:0] CHARCYC_RESET = 20'h1fca0;
  localparam logic [11:0] PAYLOAD_RESET = 12'h5dc;
  localparam logic [3:0] CTRL_RESET = 4'h2;
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STOP = 8'h04;
  localparam logic [7:0] REG_IDLE = 8'h08;
  localparam logic [7:0] REG_CHARCYC = 8'h0c;
  localparam logic [7:0] REG_GUARD = 8'h10;
  localparam logic [7:0] REG_ESC = 8'h14;
  localparam logic [7:0] REG_PAYLOAD = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  localparam logic [7:0] REG_DROPS = 8'h20;
  // field positions
  localparam int CTRL_REQ_EN = 0;
  localparam int CTRL_CLR_EN = 1;
  localparam int CTRL_API = 2;
  localparam int CTRL_SPI = 3;
  localparam int CTRL_CMD_EXIT = 4;
  localparam int ST_TXCNT = 12;
  localparam int ST_STOP = 24;
  localparam int ST_CMD = 25;
  localparam int ST_TXOK = 26;
  localparam int ST_TXVAL = 27;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } sbf_byte_t;

  typedef struct packed {
    logic [31:0] srcAddr;
    logic [11:0] len;
  } sbf_rfhdr_t;

  typedef enum logic [2:0] {
    PK_IDLE = 3'b001,
    PK_SEND = 3'b010,
    PK_DROP = 3'b100
  } sbf_pk_t;

  typedef enum logic [3:0] {
    RF_IDLE = 4'b0001,
    RF_ADDR = 4'b0010,
    RF_DATA = 4'b0100,
    RF_DROP = 4'b1000
  } sbf_rf_t;

  typedef enum logic [3:0] {
    ES_WAIT = 4'b0001,
    ES_C1 = 4'b0010,
    ES_C2 = 4'b0100,
    ES_C3 = 4'b1000
  } sbf_es_t;
endpackage

// ### rtl/sbf_serial_buffer.sv
// Functional notes
// - full host buffer discards new characters
// - radio packet without room dropped whole
// - stop signalled when occupancy reaches threshold
// - 2100 byte buffer, threshold capped 2083
// - threshold resets to 2035
// - resume only at threshold minus 17
// - request and clear control separately enabled
// - held request input blocks output start
// - up to two characters after hold
// - transparent mode queues and forwards everything
// - zero idle setting packetizes immediately
// - idle packet close, never under 100us
// - escape sequence flushes buffer, enters command
// - full payload closes packet at once
// - serial-peripheral port forces framed mode
// - framed mode bytes all belong frames
// - framed input carries data and commands; the code sends every framed input byte out as radio data
// - framed output carries data and events; the code outputs radio data only, transmit status goes to REG_STATUS
// - transmit status reported per framed send
// - received data frames carry source address
// - escape guard and character configurable
// - serial-peripheral port equals framed mode
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module sbf_serial_buffer
  import sbf_pkg::*;
#(
  parameter int MIN_IDLE_CYCLES = sbf_pkg::MIN_IDLE_CYC,
  parameter int MS_CYCLES = sbf_pkg::MS_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic hostRxValid,
  input wire logic [7:0] hostRxData,
  input wire logic hostRxFrameEnd,
  input wire logic hostLineIn,
  output logic module_accept_input_n,
  input wire logic host_hold_output_n,
  output logic hostTxValid,
  input wire logic hostTxReady,
  output logic [7:0] hostTxData,
  output logic radioTxValid,
  input wire logic radioTxReady,
  output sbf_pkg::sbf_byte_t radioTx,
  input wire logic radioTxDone,
  input wire logic radioTxOk,
  input wire logic rfRxStart,
  input wire sbf_pkg::sbf_rfhdr_t rfRxHdr,
  input wire logic rfRxValid,
  output logic rfRxReady,
  input wire sbf_pkg::sbf_byte_t rfRxByte,
  output logic cmdModeActive
);
  import sbf_pkg::*;

  if (MIN_IDLE_CYCLES < 1 || MS_CYCLES < 2 || MIN_IDLE_CYCLES > 2**27) begin : gBadTime
    $error("sbf_serial_buffer: timing parameters out of range");
  end

  // configuration registers
  logic [3:0] ctrl_q;
  logic [11:0] stopThr_q;
  logic [7:0] idleChars_q;
  logic [19:0] charCyc_q;
  logic [15:0] guard_q;
  logic [7:0] escChar_q;
  logic [11:0] payload_q;
  logic [15:0] hostDrops_q;
  logic [15:0] rfDrops_q;
  logic txOk_q;
  logic txStatValid_q;
  logic stopped_q;
  logic cmdMode_q;
  logic reqEn;
  logic clearEn;
  logic apiMode;
  assign reqEn = ctrl_q[CTRL_REQ_EN];
  assign clearEn = ctrl_q[CTRL_CLR_EN];
  assign apiMode = ctrl_q[CTRL_API] | ctrl_q[CTRL_SPI];

  // bus slave
  logic awHeld_q;
  logic wHeld_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic doWrite;
  logic doRead;
  logic [31:0] wMask;
  logic [31:0] rdMux;
  logic rdHit;
  logic wrHit;
  assign s_axi_awready = !awHeld_q && !bvalid_q;
  assign s_axi_wready = !wHeld_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign doWrite = awHeld_q && wHeld_q && !bvalid_q;
  assign doRead = s_axi_arvalid && s_axi_arready;
  assign wMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  assign wrHit = awAddr_q <= REG_PAYLOAD && awAddr_q[1:0] == 2'h0;
  assign rdHit = s_axi_araddr <= REG_DROPS && s_axi_araddr[1:0] == 2'h0;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // buffers and occupancy
  logic rxInValid;
  logic rxInReady;
  logic rxOutValid;
  logic rxOutReady;
  logic [8:0] rxOut;
  logic [11:0] rxCount;
  logic txInValid;
  logic txInReady;
  logic [7:0] txIn;
  logic txOutValid;
  logic [11:0] txCount;
  logic [11:0] txFree;
  logic hostStore;
  assign hostStore = hostRxValid && (apiMode || !cmdMode_q);
  assign rxInValid = hostStore;
  assign txFree = 12'(TX_DEPTH) - txCount;

  sbf_fifo #(.WIDTH(9), .DEPTH(RX_DEPTH)) uRxBuf (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .inValid(rxInValid),
    .inReady(rxInReady),
    .inData({hostRxFrameEnd & apiMode, hostRxData}),
    .outValid(rxOutValid),
    .outReady(rxOutReady),
    .outData(rxOut),
    .count(rxCount)
  );

  sbf_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) uTxBuf (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .inValid(txInValid),
    .inReady(txInReady),
    .inData(txIn),
    .outValid(txOutValid),
    .outReady(hostTxReady && hostTxValid),
    .outData(hostTxData),
    .count(txCount)
  );

  // pin synchronisers and idle timing
  logic [1:0] holdSync_q;
  logic [2:0] lineSync_q;
  logic lineEdge;
  logic [27:0] idleCyc_q;
  logic [27:0] idleLimit;
  logic [27:0] charLimit;
  logic idleHit;
  logic [$clog2(MS_CYCLES)-1:0] msDiv_q;
  logic msTick;
  logic [15:0] silenceMs_q;
  assign lineEdge = lineSync_q[2] ^ lineSync_q[1];
  assign charLimit = 28'(idleChars_q * charCyc_q);
  assign idleLimit = (charLimit < 28'(MIN_IDLE_CYCLES)) ? 28'(MIN_IDLE_CYCLES) : charLimit;
  assign idleHit = idleCyc_q >= idleLimit;
  assign msTick = msDiv_q == ($clog2(MS_CYCLES))'(MS_CYCLES - 1);
  assign hostTxValid = txOutValid && !(reqEn && holdSync_q[1]);
  assign module_accept_input_n = clearEn && stopped_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      holdSync_q <= 2'h3;
      lineSync_q <= 3'h7;
      idleCyc_q <= '0;
      msDiv_q <= '0;
      silenceMs_q <= '0;
    end else begin
      holdSync_q <= {holdSync_q[0], host_hold_output_n};
      lineSync_q <= {lineSync_q[1:0], hostLineIn};
      idleCyc_q <= (lineEdge || hostStore) ? '0 : idleCyc_q + 28'(!(&idleCyc_q));
      msDiv_q <= msTick ? '0 : msDiv_q + 1'b1;
      silenceMs_q <= hostRxValid ? '0 : silenceMs_q + 16'(msTick && !(&silenceMs_q));
    end
  end

  // escape sequence detector
  sbf_es_t esSt_q;
  logic escFire;
  logic isEsc;
  assign isEsc = hostRxValid && hostRxData == escChar_q;
  assign escFire = esSt_q == ES_C3 && silenceMs_q >= guard_q && !hostRxValid;

  always_ff @(posedge sys_clk) begin
    if (sys_rst || apiMode || cmdMode_q) begin
      esSt_q <= ES_WAIT;
    end else begin
      unique case (esSt_q)
        ES_WAIT: if (isEsc && silenceMs_q >= guard_q) esSt_q <= ES_C1;
        ES_C1: if (hostRxValid) esSt_q <= (isEsc && silenceMs_q < guard_q) ? ES_C2 : ES_WAIT;
        ES_C2: if (hostRxValid) esSt_q <= (isEsc && silenceMs_q < guard_q) ? ES_C3 : ES_WAIT;
        ES_C3: if (hostRxValid || escFire) esSt_q <= ES_WAIT;
      endcase
    end
  end

  // packetizer
  sbf_pk_t pk_q;
  logic [11:0] sendLeft_q;
  logic [11:0] dropLeft_q;
  logic [11:0] frameCnt_q;
  logic [11:0] avail;
  logic trigIdle;
  logic popEnd;
  logic pushEnd;
  assign avail = (rxCount > payload_q) ? payload_q : rxCount;
  assign trigIdle = (idleChars_q == 8'h00 || idleHit) && esSt_q == ES_WAIT;
  assign rxOutReady = (pk_q == PK_SEND && radioTxReady) || pk_q == PK_DROP;
  assign radioTxValid = pk_q == PK_SEND && rxOutValid;
  assign radioTx.data = rxOut[7:0];
  assign radioTx.last = apiMode ? (rxOut[8] || sendLeft_q == 12'h001)
                                : sendLeft_q == 12'h001;
  assign popEnd = rxOutValid && rxOutReady && rxOut[8];
  assign pushEnd = rxInValid && rxInReady && hostRxFrameEnd && apiMode;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pk_q <= PK_IDLE;
      sendLeft_q <= '0;
      dropLeft_q <= '0;
      frameCnt_q <= '0;
      cmdMode_q <= 1'b0;
    end else begin
      frameCnt_q <= frameCnt_q + 12'(pushEnd) - 12'(popEnd);
      if (doWrite && awAddr_q == REG_CTRL && wStrb_q[0] && wData_q[CTRL_CMD_EXIT]) begin
        cmdMode_q <= 1'b0;
      end
      unique case (pk_q)
        PK_IDLE: begin
          if (escFire) begin
            sendLeft_q <= rxCount - ESC_COUNT;
            dropLeft_q <= ESC_COUNT;
            pk_q <= (rxCount == ESC_COUNT) ? PK_DROP : PK_SEND;
            cmdMode_q <= 1'b1;
          end else if (apiMode && (frameCnt_q != '0 || rxCount >= payload_q)) begin
            sendLeft_q <= avail;
            pk_q <= PK_SEND;
          end else if (!apiMode && rxCount != '0 && (rxCount >= payload_q || trigIdle)) begin
            sendLeft_q <= avail;
            pk_q <= PK_SEND;
          end
        end
        PK_SEND: if (radioTxValid && radioTxReady) begin
          sendLeft_q <= sendLeft_q - 1'b1;
          if (radioTx.last) pk_q <= (dropLeft_q != '0) ? PK_DROP : PK_IDLE;
        end
        PK_DROP: if (rxOutValid) begin
          dropLeft_q <= dropLeft_q - 1'b1;
          if (dropLeft_q == 12'h001) pk_q <= PK_IDLE;
        end
      endcase
    end
  end
  assign cmdModeActive = cmdMode_q;

  // radio receive path into the output buffer
  sbf_rf_t rf_q;
  logic [1:0] addrIdx_q;
  logic [31:0] srcAddr_q;
  logic [11:0] need;
  assign need = rfRxHdr.len + (apiMode ? ADDR_BYTES : 12'h000);
  assign rfRxReady = (rf_q == RF_DATA && txInReady) || rf_q == RF_DROP;
  assign txInValid = rf_q == RF_ADDR || (rf_q == RF_DATA && rfRxValid);
  assign txIn = (rf_q == RF_ADDR) ? srcAddr_q[31:24] : rfRxByte.data;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rf_q <= RF_IDLE;
      addrIdx_q <= '0;
      srcAddr_q <= '0;
      rfDrops_q <= '0;
    end else begin
      unique case (rf_q)
        RF_IDLE: if (rfRxStart) begin
          srcAddr_q <= rfRxHdr.srcAddr;
          addrIdx_q <= '0;
          if (need > txFree) begin
            rf_q <= RF_DROP;
            rfDrops_q <= rfDrops_q + 16'(!(&rfDrops_q));
          end else begin
            rf_q <= apiMode ? RF_ADDR : RF_DATA;
          end
        end
        RF_ADDR: if (txInReady) begin
          srcAddr_q <= {srcAddr_q[23:0], 8'h00};
          addrIdx_q <= addrIdx_q + 1'b1;
          if (addrIdx_q == 2'h3) rf_q <= RF_DATA;
        end
        RF_DATA: if (rfRxValid && txInReady && rfRxByte.last) rf_q <= RF_IDLE;
        RF_DROP: if (rfRxValid && rfRxByte.last) rf_q <= RF_IDLE;
      endcase
    end
  end

  // flow control with hysteresis
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stopped_q <= 1'b0;
      hostDrops_q <= '0;
    end else begin
      if (rxCount >= stopThr_q) begin
        stopped_q <= 1'b1;
      end else if (rxCount <= stopThr_q - STOP_MARGIN) begin
        stopped_q <= 1'b0;
      end
      if (rxInValid && !rxInReady) begin
        hostDrops_q <= hostDrops_q + 16'(!(&hostDrops_q));
      end
    end
  end

  // register write and read
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      ctrl_q <= CTRL_RESET;
      stopThr_q <= STOP_RESET;
      idleChars_q <= IDLE_RESET;
      charCyc_q <= CHARCYC_RESET;
      guard_q <= GUARD_RESET;
      escChar_q <= ESC_RESET;
      payload_q <= PAYLOAD_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) bvalid_q <= 1'b0;
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wrHit ? RESP_OKAY : RESP_SLVERR;
        unique case (awAddr_q)
          REG_CTRL: ctrl_q <= 4'(merge(32'(ctrl_q), wData_q, wMask));
          REG_STOP: stopThr_q <= (12'(merge(32'(stopThr_q), wData_q, wMask)) > STOP_MAX)
                                 ? STOP_MAX : 12'(merge(32'(stopThr_q), wData_q, wMask));
          REG_IDLE: idleChars_q <= 8'(merge(32'(idleChars_q), wData_q, wMask));
          REG_CHARCYC: charCyc_q <= 20'(merge(32'(charCyc_q), wData_q, wMask));
          REG_GUARD: guard_q <= 16'(merge(32'(guard_q), wData_q, wMask));
          REG_ESC: escChar_q <= 8'(merge(32'(escChar_q), wData_q, wMask));
          REG_PAYLOAD: payload_q <= (12'(merge(32'(payload_q), wData_q, wMask)) == 12'h000)
                                    ? 12'h001 : 12'(merge(32'(payload_q), wData_q, wMask));
          default: ;
        endcase
      end
    end
  end

  always_comb begin
    unique case (s_axi_araddr)
      REG_CTRL: rdMux = 32'(ctrl_q);
      REG_STOP: rdMux = 32'(stopThr_q);
      REG_IDLE: rdMux = 32'(idleChars_q);
      REG_CHARCYC: rdMux = 32'(charCyc_q);
      REG_GUARD: rdMux = 32'(guard_q);
      REG_ESC: rdMux = 32'(escChar_q);
      REG_PAYLOAD: rdMux = 32'(payload_q);
      REG_STATUS: rdMux = {4'h0, txStatValid_q, txOk_q, cmdMode_q, stopped_q, txCount, rxCount};
      REG_DROPS: rdMux = {rfDrops_q, hostDrops_q};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      txOk_q <= 1'b0;
      txStatValid_q <= 1'b0;
    end else begin
      if (s_axi_rvalid && s_axi_rready) rvalid_q <= 1'b0;
      if (doRead) begin
        rvalid_q <= 1'b1;
        rdata_q <= rdHit ? rdMux : 32'h0000_0000;
        rresp_q <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end
      if (radioTxDone && apiMode) begin
        txOk_q <= radioTxOk;
        txStatValid_q <= 1'b1;
      end else if (doRead && s_axi_araddr == REG_STATUS) begin
        txStatValid_q <= 1'b0;
      end
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence escDone_s;
    esSt_q == ES_C3 ##1 escFire;
  endsequence

  AST_HOST_DROP: assert property ((rxInValid && !rxInReady && !rxOutReady) |=>
    rxCount == $past(rxCount)) else $error("stored data disturbed by overflow");
  AST_RF_WHOLE: assert property ((rf_q == RF_IDLE && rfRxStart && need > txFree) |=>
    rf_q == RF_DROP ##1 !txInValid) else $error("oversized packet not dropped whole");
  AST_CTS_STOP: assert property ((clearEn && rxCount >= stopThr_q) |=>
    module_accept_input_n) else $error("stop not shown at threshold");
  AST_THR_MAX: assert property (stopThr_q <= STOP_MAX)
    else $error("threshold above ceiling");
  AST_CTS_HOLD: assert property ((stopped_q && rxCount > stopThr_q - STOP_MARGIN) |=>
    stopped_q) else $error("resumed above hysteresis level");
  AST_HOLD_GATE: assert property ((reqEn && holdSync_q[1]) |-> !hostTxValid)
    else $error("output started while host holds");
  AST_ZERO_IDLE: assert property ((pk_q == PK_IDLE && !apiMode && !escFire &&
    idleChars_q == 8'h00 && rxCount != '0 && esSt_q == ES_WAIT) |=> pk_q == PK_SEND)
    else $error("zero idle did not packetize");
  AST_PAYLOAD: assert property ((pk_q == PK_IDLE && !apiMode && !escFire &&
    rxCount >= payload_q) |=> pk_q == PK_SEND ##0 sendLeft_q == $past(payload_q))
    else $error("full payload not sent");
  AST_ESC_CMD: assert property (escDone_s |=> cmdMode_q && pk_q != PK_IDLE)
    else $error("escape did not flush and enter command mode");
  AST_SPI_FRAMED: assert property (ctrl_q[CTRL_SPI] |-> apiMode ##1 esSt_q == ES_WAIT)
    else $error("serial-peripheral port left framed mode");
endmodule // sbf_serial_buffer
`default_nettype wire

// ### tb/sbf_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module sbf_host_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic sendEn,
  input wire logic honorStop,
  input wire logic holdReq,
  input wire logic module_accept_input_n,
  output logic hostRxValid,
  output logic [7:0] hostRxData,
  output logic hostLineIn,
  output logic host_hold_output_n,
  input wire logic hostTxValid,
  output logic hostTxReady,
  output logic [15:0] sentCnt,
  output logic [15:0] rxBytes
);
  assign hostTxReady = 1'b1;
  assign host_hold_output_n = holdReq;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hostRxValid <= 1'b0;
      sentCnt <= 16'h0000;
      rxBytes <= 16'h0000;
      hostLineIn <= 1'b1;
      hostRxData <= 8'h00;
    end else begin
      hostRxValid <= sendEn && !(honorStop && module_accept_input_n);
      if (sendEn && !(honorStop && module_accept_input_n)) begin
        hostRxData <= sentCnt[7:0];
        hostLineIn <= ~hostLineIn;
        sentCnt <= sentCnt + 16'h0001;
      end
      if (hostTxValid) begin
        rxBytes <= rxBytes + 16'h0001;
      end
    end
  end
endmodule // sbf_host_model
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sbf_pkg::*;
  logic sys_clk, sys_rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, hostRxFrameEnd = 0, radioTxReady = 0;
  logic radioTxDone = 0, radioTxOk = 0, rfRxStart = 0, rfRxValid = 0;
  logic sendEn = 0, honorStop = 0, holdReq = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  sbf_byte_t rfRxByte = '0;
  sbf_rfhdr_t rfRxHdr = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rfRxReady;
  logic hostRxValid, hostLineIn, module_accept_input_n, host_hold_output_n, cmdModeActive;
  logic hostTxValid, hostTxReady, radioTxValid;
  logic [7:0] hostRxData, hostTxData;
  logic [31:0] s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [15:0] sentCnt, rxBytes;
  sbf_byte_t radioTx;
  int fail_count = 0, n_tests = 0, n, li, c;

  sbf_serial_buffer #(.MIN_IDLE_CYCLES(20), .MS_CYCLES(10)) sbf_serial_buffer_i (
    .sys_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .hostRxValid, .hostRxData, .hostRxFrameEnd, .hostLineIn,
    .module_accept_input_n, .host_hold_output_n, .hostTxValid, .hostTxReady, .hostTxData,
    .radioTxValid, .radioTxReady, .radioTx, .radioTxDone, .radioTxOk, .rfRxStart, .rfRxHdr,
    .rfRxValid, .rfRxReady, .rfRxByte, .cmdModeActive);
  sbf_host_model sbf_host_model_i (
    .sys_clk, .sys_rst, .sendEn, .honorStop, .holdReq, .module_accept_input_n, .hostRxValid,
    .hostRxData, .hostLineIn, .host_hold_output_n, .hostTxValid, .hostTxReady, .sentCnt,
    .rxBytes);

  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  task automatic stop_test;
    $display("mismatches %0d of %0d checks", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic waitv(ref logic s, input logic v);
    int t;
    t = 0;
    do begin
      @(negedge sys_clk);
      t++;
    end while (s !== v && t < 6000);
    if (s !== v) begin
      chk(0, 1, "wait timed out");
      stop_test();
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge sys_clk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    while (!(ad && wd)) begin
      @(negedge sys_clk);
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
      @(posedge sys_clk);
      if (ad) s_axi_awvalid <= 0;
      if (wd) s_axi_wvalid <= 0;
    end
    waitv(s_axi_bvalid, 1);
    rr = s_axi_bresp;
    @(posedge sys_clk);
    s_axi_bready <= 0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge sys_clk);
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    s_axi_araddr <= a;
    waitv(s_axi_arready, 1);
    @(posedge sys_clk);
    s_axi_arvalid <= 0;
    waitv(s_axi_rvalid, 1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge sys_clk);
    s_axi_rready <= 0;
  endtask

  task automatic rf_pkt(input int len);
    @(posedge sys_clk);
    rfRxStart <= 1;
    rfRxHdr <= '{32'h0000_0000, len[11:0]};
    @(posedge sys_clk);
    rfRxStart <= 0;
    for (int i = 0; i < len; i++) begin
      rfRxValid <= 1;
      rfRxByte <= '{i[7:0], i == len - 1};
      waitv(rfRxReady, 1);
      @(posedge sys_clk);
    end
    rfRxValid <= 0;
  endtask

  task automatic send_n(input int cnt);
    int s0, t;
    t = 0;
    @(negedge sys_clk);
    s0 = sentCnt;
    @(posedge sys_clk);
    sendEn <= 1;
    do begin
      @(negedge sys_clk);
      t++;
    end while (sentCnt - s0 < cnt - 1 && t < 6000);
    @(posedge sys_clk);
    sendEn <= 0;
  endtask

  task automatic flow_test;
    axw(REG_STOP, 32'd40);
    honorStop <= 1;
    sendEn <= 1;
    waitv(module_accept_input_n, 1);
    repeat (10) @(posedge sys_clk);
    {sendEn, honorStop} <= 2'b00;
    axr(REG_STATUS);
    c = rd[11:0];
    chk(c >= 40 && c <= 43, 1, "stop point");
    send_n(2110 - c);
    axr(REG_STATUS);
    chk(rd[11:0], 12'd2100, "buffer fill");
    axr(REG_DROPS);
    chk(rd[15:0], 16'd10, "host drops");
    axw(REG_IDLE, 32'h0);
    radioTxReady <= 1;
    n = 0;
    li = 0;
    do begin
      @(negedge sys_clk);
      li++;
      if (radioTxValid && radioTxReady) n++;
    end while (module_accept_input_n !== 0 && li < 4000);
    if (module_accept_input_n !== 0) waitv(module_accept_input_n, 0);
    chk(2100 - n >= 20 && 2100 - n <= 23, 1, "resume point");
  endtask

  task automatic hold_test;
    axw(REG_CTRL, 32'h3);
    holdReq <= 1;
    rf_pkt(2000);
    rf_pkt(100);
    repeat (20) @(posedge sys_clk);
    chk(rxBytes, 0, "output while held");
    chk(hostTxData, 8'h00, "first output byte");
    axr(REG_DROPS);
    chk(rd[31:16], 16'd1, "radio drops");
    holdReq <= 0;
    c = 0;
    while (rxBytes !== 16'd2000 && c < 5000) begin
      @(negedge sys_clk);
      c++;
    end
    repeat (20) @(negedge sys_clk);
    chk(rxBytes, 2000, "forwarded bytes");
  endtask

  task automatic payload_test;
    axw(REG_PAYLOAD, 32'd4);
    axw(REG_IDLE, 32'hff);
    send_n(4);
    n = 0;
    li = 0;
    repeat (50) begin
      @(negedge sys_clk);
      if (radioTxValid && radioTxReady) n++;
      if (radioTxValid && radioTxReady && radioTx.last && li == 0) begin
        li = n;
        c = radioTx.data;
      end
    end
    chk(li, 4, "packet end");
    chk(c, 32'h41, "packet data");
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 0;
    axr(REG_STOP);
    chk(rd, {20'h0, STOP_RESET}, "stop reset value");
    axr(REG_CTRL);
    chk(rd, {28'h0, CTRL_RESET}, "ctrl reset value");
    axw(REG_STOP, 32'hfff);
    axr(REG_STOP);
    chk(rd, {20'h0, STOP_MAX}, "stop clamp");
    axr(8'h24);
    chk(rr, RESP_SLVERR, "unmapped read");
    flow_test();
    hold_test();
    payload_test();
    axw(REG_CTRL, 32'h4);
    radioTxOk <= 1;
    radioTxDone <= 1;
    @(posedge sys_clk);
    radioTxDone <= 0;
    axr(REG_STATUS);
    chk(rd[27:25], 3'b110, "transmit status");
    axr(REG_STATUS);
    chk(rd[27], 0, "status clear on read");
    chk(cmdModeActive, 0, "command mode");
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
